// ---- test_usb_function_device_control.sv ----
// testbench for usb function device control
`timescale 1ns/1ps
module test_usb_function_device_control;
  import ufdc_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rst_seen, sus_seen, res_seen, sof;
  logic req_done, usb_irq, drive_resume, inhibit, flush, flush_seen, lane;
  logic [31:0] awaddr, wdata, araddr, rdata, rv;
  logic [3:0]  wstrb, ev_in, rdy_set, sent, armed;
  logic [1:0]  bresp, rresp;
  logic [6:0]  act_addr, a, prev;
  int          fails, compares, cycles, rnd;

  ufdc_device_control dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .bus_reset_seen(rst_seen), .bus_suspend_seen(sus_seen),
    .bus_resume_seen(res_seen), .bus_sof(sof), .request_done(req_done),
    .in_endpoint_event(ev_in), .in_packet_ready_set(rdy_set), .in_packet_sent(sent),
    .usb_irq(usb_irq), .drive_resume(drive_resume), .function_inhibit(inhibit),
    .endpoint_flush(flush), .active_address(act_addr), .in_packet_armed(armed));
  ufdc_host_model host_u (.aclk(aclk), .bus_reset_seen(rst_seen),
    .bus_suspend_seen(sus_seen), .bus_resume_seen(res_seen), .bus_sof(sof));

  always #2 aclk = ~aclk;
  always @(posedge aclk) if (flush === 1'b1) flush_seen <= 1'b1;
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [1:0] exp_resp(input logic [7:0] idx);
    case (idx)
      IDX_FUNCTION_ADDRESS, IDX_POWER_CONTROL, IDX_IN_EP_FLAGS, IDX_COMMON_FLAGS,
      IDX_IN_EP_ENABLES, IDX_COMMON_ENABLES, IDX_EVENT_STATUS: exp_resp = RESP_OKAY;
      default: exp_resp = RESP_SLVERR;
    endcase
  endfunction : exp_resp

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge aclk);
    awaddr  <= {22'h00_0000, idx, 2'b00};
    wdata   <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    wstrb   <= {3'($urandom), lane};
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1 && !aw_ok) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !w_ok) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_ok && w_ok));
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk("bresp", {30'h0, exp_resp(idx)}, {30'h0, bresp});
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= {22'h00_0000, idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rv = rdata;
    rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : rd

  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    rd(idx, RESP_OKAY);
    chk($sformatf("reg %0h", idx), {24'h00_0000, e}, rv);
  endtask : rdc

  // one cycle pulse on the endpoint side inputs
  task automatic ep(input logic [3:0] e, input logic [3:0] s, input logic [3:0] t,
                    input logic d);
    @(posedge aclk);
    ev_in <= e; rdy_set <= s; sent <= t; req_done <= d;
    @(posedge aclk);
    ev_in <= 4'h0; rdy_set <= 4'h0; sent <= 4'h0; req_done <= 1'b0;
  endtask : ep

  initial begin
    aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0;
    rready = 0; awaddr = 0; wdata = 0; araddr = 0; wstrb = 4'hF; ev_in = 0;
    rdy_set = 0; sent = 0; req_done = 0; flush_seen = 0; fails = 0;
    compares = 0; cycles = 0; lane = 1'b1; prev = 7'h00;
    rnd = $urandom(32'h95fe);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(IDX_POWER_CONTROL, 8'h10);
    rdc(IDX_IN_EP_FLAGS, 8'h00);
    rdc(IDX_IN_EP_ENABLES, 8'h0F);
    rdc(IDX_COMMON_ENABLES, 8'h06);
    rd(8'h3F, RESP_SLVERR);
    chk("unmapped data", 32'h0000_0000, rv);
    rd(8'($urandom_range(8'h11, 8'hFF)), RESP_SLVERR);
    wr(8'($urandom_range(8'h11, 8'hFF)), 8'($urandom));
    // configuration order: force reset, enables, then suspend detect and clear inhibit in one write
    wr(IDX_POWER_CONTROL, 8'h08);
    cyc(4);
    rdc(IDX_POWER_CONTROL, 8'h10);
    wr(IDX_COMMON_ENABLES, 8'h0F);
    // a write without byte lane 0 must leave the register alone
    lane = 1'b0;
    wr(IDX_COMMON_ENABLES, 8'h00);
    lane = 1'b1;
    rdc(IDX_COMMON_ENABLES, 8'h0F);
    wr(IDX_POWER_CONTROL, 8'h01);
    cyc(2);
    chk("inhibit", 32'h0, {31'h0, inhibit});
    wr(IDX_POWER_CONTROL, 8'h11);
    rdc(IDX_POWER_CONTROL, 8'h01);
    for (int i = 0; i < 3; i++) begin
      a = 7'($urandom_range(1, 127));
      wr(IDX_FUNCTION_ADDRESS, {1'b0, a});
      rdc(IDX_FUNCTION_ADDRESS, {1'b1, a});
      chk("addr before done", {25'h0, prev}, {25'h0, act_addr});
      ep(4'h0, 4'h0, 4'h0, 1'b1);
      cyc(2);
      chk("active addr", {25'h0, a}, {25'h0, act_addr});
      rdc(IDX_FUNCTION_ADDRESS, {1'b0, a});
      prev = a;
    end
    for (int i = 0; i < 4; i++) begin
      a = 7'($urandom_range(1, 15));
      ep(a[3:0], 4'h0, 4'($urandom), 1'($urandom));
      cyc(2);
      chk("irq", 32'h1, {31'h0, usb_irq});
      rdc(IDX_IN_EP_FLAGS, {4'h0, a[3:0]});
      rdc(IDX_IN_EP_FLAGS, 8'h00);
      cyc(2);
      chk("irq clear", 32'h0, {31'h0, usb_irq});
    end
    wr(IDX_IN_EP_ENABLES, 8'h05);
    ep(4'hF, 4'h0, 4'h0, 1'b0);
    rdc(IDX_IN_EP_FLAGS, 8'h05);
    wr(IDX_IN_EP_ENABLES, 8'h0F);
    wr(IDX_IN_EP_FLAGS, 8'hFF);
    rdc(IDX_IN_EP_FLAGS, 8'h00);
    host_u.bus_event(0);
    cyc(2);
    chk("irq suspend", 32'h1, {31'h0, usb_irq});
    rdc(IDX_POWER_CONTROL, 8'h03);
    rdc(IDX_EVENT_STATUS, {6'h00, UFDC_SUSPEND});
    rdc(IDX_COMMON_FLAGS, 8'h01);
    host_u.bus_event(1);
    rdc(IDX_POWER_CONTROL, 8'h03);
    rdc(IDX_EVENT_STATUS, {5'h00, 1'b1, UFDC_WAKE});
    rdc(IDX_COMMON_FLAGS, 8'h02);
    rdc(IDX_POWER_CONTROL, 8'h01);
    host_u.bus_event(0);
    rdc(IDX_COMMON_FLAGS, 8'h01);
    wr(IDX_POWER_CONTROL, 8'h05);
    cyc(2);
    chk("drive resume", 32'h1, {31'h0, drive_resume});
    // wakeup length scaled down from milliseconds to keep the run short
    cyc(50);
    wr(IDX_POWER_CONTROL, 8'h01);
    cyc(2);
    chk("resume end", 32'h0, {31'h0, drive_resume});
    chk("irq wake", 32'h1, {31'h0, usb_irq});
    rdc(IDX_POWER_CONTROL, 8'h01);
    rd(IDX_COMMON_FLAGS, RESP_OKAY);
    wr(IDX_POWER_CONTROL, 8'h00);
    host_u.bus_event(0);
    rdc(IDX_POWER_CONTROL, 8'h00);
    rdc(IDX_COMMON_FLAGS, 8'h00);
    wr(IDX_POWER_CONTROL, 8'h80);
    ep(4'h0, 4'h0, 4'($urandom), 1'b0);
    a = 7'($urandom_range(1, 15));
    ep(4'h0, a[3:0], 4'h0, 1'b0);
    cyc(2);
    chk("armed before sof", {28'h0, ~a[3:0]}, {28'h0, armed});
    host_u.bus_event(2);
    cyc(2);
    chk("armed after sof", 32'hF, {28'h0, armed});
    wr(IDX_POWER_CONTROL, 8'h01);
    ep(4'h0, 4'h0, 4'($urandom), 1'b0);
    ep(4'h0, 4'h4, 4'h0, 1'b0);
    cyc(2);
    chk("armed no gate", 32'hF, {28'h0, armed});
    rd(IDX_COMMON_FLAGS, RESP_OKAY);
    wr(IDX_COMMON_ENABLES, 8'h01);
    host_u.bus_event(0);
    host_u.bus_reset(1'b1);
    cyc(3);
    rd(IDX_POWER_CONTROL, RESP_OKAY);
    chk("reset bit live", 32'h1, {31'h0, rv[PWR_RESET]});
    chk("suspend exit", 32'h0, {31'h0, rv[PWR_SUSPEND_MD]});
    chk("flush", 32'h1, {31'h0, flush_seen});
    chk("addr zeroed", 32'h0, {25'h0, act_addr});
    host_u.bus_reset(1'b0);
    cyc(2);
    rd(IDX_POWER_CONTROL, RESP_OKAY);
    chk("reset bit idle", 32'h0, {31'h0, rv[PWR_RESET]});
    rdc(IDX_FUNCTION_ADDRESS, 8'h00);
    rdc(IDX_COMMON_ENABLES, 8'h0F);
    rdc(IDX_COMMON_FLAGS, 8'h04);
    host_u.bus_event(2);
    rdc(IDX_COMMON_FLAGS, 8'h08);
    wr(IDX_POWER_CONTROL, 8'h08);
    cyc(4);
    chk("inhibit set", 32'h1, {31'h0, inhibit});
    rdc(IDX_IN_EP_ENABLES, 8'h0F);
    host_u.bus_reset(1'b1);
    cyc(3);
    host_u.bus_reset(1'b0);
    rdc(IDX_COMMON_FLAGS, 8'h00);
    end_sim();
  end
endmodule : test_usb_function_device_control

// ---- ufdc_device_control.sv ----
// device level control for a usb function: address, power, flags, axi slave
// Behaviour
// [RULE1] address write sets pending; cleared when applied
// [RULE2] seven bit address applied after request completes
// [RULE3] bus reset sets flag, zeros address, flushes
// [RULE4] bus reset enables all but suspend, clears
// [RULE5] writing reset bit resets all usb registers
// [RULE6] reset bit reads live bus reset state
// [RULE7] suspend detect enabled enters suspend, sets flag
// [RULE8] leave suspend on resume, reset, device reset
// [RULE9] resume while suspended exits, raises resume flag
// [RULE10] force resume drives wakeup; clearing ends suspend
// [RULE11] software clears force resume after 10-15 ms
// [RULE12] common flag read after resume clears suspend
// [RULE13] iso gating holds packet until next sof
// [RULE14] no gating sends packet at next token
// [RULE15] inhibit set at reset, software only clears
// [RULE16] inhibit ignores all usb traffic; request_done still applies a pending address while inhibited
// [RULE17] software configures before clearing inhibit
// [RULE18] irq asserted while any flag set
// [RULE19] reading a flag register clears it
// [RULE20] in flags bits 3-0, upper bits zero
// [RULE21] common flags for reset, resume, suspend, sof
// [RULE22] per source enables; in enables reset to ones
// [RULE23] flags set only for enabled sources; bus reset sets the reset flag whatever its enable
`timescale 1ns/1ps
module ufdc_device_control
  import ufdc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        bus_reset_seen,
  input  wire logic        bus_suspend_seen,
  input  wire logic        bus_resume_seen,
  input  wire logic        bus_sof,
  input  wire logic        request_done,
  input  wire logic [3:0]  in_endpoint_event,
  input  wire logic [3:0]  in_packet_ready_set,
  input  wire logic [3:0]  in_packet_sent,
  output logic             usb_irq,
  output logic             drive_resume,
  output logic             function_inhibit,
  output logic             endpoint_flush,
  output logic [6:0]       active_address,
  output logic [3:0]       in_packet_armed
);
  logic [6:0]     new_address;
  logic           address_pending;
  logic           suspend_detect_enable;
  logic           iso_sof_gating;
  logic           force_resume;
  logic [3:0]     in_endpoint_irq_flags;
  logic [3:0]     common_irq_flags;
  logic [3:0]     in_endpoint_irq_enables;
  logic [3:0]     common_irq_enables;
  logic           resume_seen;
  ufdc_state_type state;
  logic [1:0]     soft_reset_count;
  logic           usb_rst_n;
  logic           traffic_on;
  logic           aw_held;
  logic           w_held;
  logic [7:0]     aw_index;
  logic [7:0]     w_byte;
  logic           w_lane0;
  logic           wr_fire;
  logic           rd_fire;
  logic [7:0]     rd_index;
  logic [7:0]     next_rdata;
  logic           next_rerr;
  logic           wr_addr_hit;
  logic           wr_power_hit;
  logic           rd_in_hit;
  logic           rd_cm_hit;
  logic           suspend_event;
  logic           resume_event;
  logic           wake_end;
  logic [3:0]     armed_raw;

  function automatic logic [7:0] word_index(input logic [31:0] addr);
    word_index = addr[9:2];
  endfunction : word_index

  function automatic logic known_index(input logic [7:0] idx);
    known_index = (idx == IDX_FUNCTION_ADDRESS) || (idx == IDX_POWER_CONTROL) ||
                  (idx == IDX_IN_EP_FLAGS) || (idx == IDX_COMMON_FLAGS) ||
                  (idx == IDX_IN_EP_ENABLES) || (idx == IDX_COMMON_ENABLES) ||
                  (idx == IDX_EVENT_STATUS);
  endfunction : known_index

  // write channel capture, address and data in either order
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_index = word_index(s_axi_araddr);
  assign wr_addr_hit  = wr_fire && w_lane0 && (aw_index == IDX_FUNCTION_ADDRESS);
  assign wr_power_hit = wr_fire && w_lane0 && (aw_index == IDX_POWER_CONTROL);
  assign rd_in_hit = rd_fire && (rd_index == IDX_IN_EP_FLAGS);
  assign rd_cm_hit = rd_fire && (rd_index == IDX_COMMON_FLAGS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_index      <= 8'h00;
      w_byte        <= 8'h00;
      w_lane0       <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_index      <= word_index(s_axi_awaddr);
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_byte       <= s_axi_wdata[7:0];
        w_lane0      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known_index(aw_index) ? RESP_OKAY : RESP_SLVERR;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read data decode
  always_comb begin
    next_rdata = 8'h00;
    next_rerr  = 1'b0;
    case (rd_index)
      IDX_FUNCTION_ADDRESS: next_rdata = {address_pending, new_address};
      IDX_POWER_CONTROL: begin
        next_rdata[PWR_ISO_GATE]   = iso_sof_gating;
        next_rdata[PWR_INHIBIT]    = function_inhibit;
        next_rdata[PWR_RESET]      = bus_reset_seen; // see [RULE6]
        next_rdata[PWR_RESUME]     = force_resume;
        next_rdata[PWR_SUSPEND_MD] = (state != UFDC_ACTIVE);
        next_rdata[PWR_SUSPEND_EN] = suspend_detect_enable;
      end
      IDX_IN_EP_FLAGS:    next_rdata = {4'h0, in_endpoint_irq_flags}; // see [RULE20]
      IDX_COMMON_FLAGS:   next_rdata = {4'h0, common_irq_flags};
      IDX_IN_EP_ENABLES:  next_rdata = {4'h0, in_endpoint_irq_enables};
      IDX_COMMON_ENABLES: next_rdata = {4'h0, common_irq_enables};
      IDX_EVENT_STATUS:   next_rdata = {5'h00, resume_seen, state};
      default:            next_rerr = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, next_rdata};
      s_axi_rresp   <= next_rerr ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // software reset: writing one to the reset bit pulses an internal reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_reset_count <= 2'd0;
    end else if (wr_power_hit && w_byte[PWR_RESET]) begin
      soft_reset_count <= SOFT_RESET_CYCLES; // see [RULE5]
    end else if (soft_reset_count != 2'd0) begin
      soft_reset_count <= soft_reset_count - 2'd1;
    end
  end
  assign usb_rst_n = aresetn && (soft_reset_count == 2'd0);
  assign traffic_on = !function_inhibit; // see [RULE16]

  // function address and pending flag
  always_ff @(posedge aclk) begin
    if (!usb_rst_n) begin
      new_address     <= 7'h00;
      active_address  <= 7'h00;
      address_pending <= 1'b0;
    end else if (traffic_on && bus_reset_seen) begin
      new_address     <= 7'h00; // see [RULE3]
      active_address  <= 7'h00;
      address_pending <= 1'b0;
    end else if (wr_addr_hit) begin
      new_address     <= w_byte[6:0];
      address_pending <= 1'b1; // see [RULE1]
    end else if (address_pending && request_done) begin
      active_address  <= new_address; // see [RULE2]
      address_pending <= 1'b0; // see [RULE1]
    end
  end

  // power control bits
  always_ff @(posedge aclk) begin
    if (!usb_rst_n) begin
      function_inhibit      <= RST_POWER_CONTROL[PWR_INHIBIT]; // see [RULE15]
      suspend_detect_enable <= RST_POWER_CONTROL[PWR_SUSPEND_EN];
      iso_sof_gating        <= RST_POWER_CONTROL[PWR_ISO_GATE];
      force_resume          <= RST_POWER_CONTROL[PWR_RESUME];
    end else if (wr_power_hit) begin
      function_inhibit      <= function_inhibit & w_byte[PWR_INHIBIT]; // see [RULE15]
      suspend_detect_enable <= w_byte[PWR_SUSPEND_EN];
      iso_sof_gating        <= w_byte[PWR_ISO_GATE];
      force_resume          <= w_byte[PWR_RESUME] && (state != UFDC_ACTIVE);
    end
  end

  // suspend state machine
  assign suspend_event = traffic_on && suspend_detect_enable && bus_suspend_seen
                         && (state == UFDC_ACTIVE) && !bus_reset_seen; // see [RULE7]
  assign resume_event  = traffic_on && bus_resume_seen && (state == UFDC_SUSPEND);
  assign wake_end      = wr_power_hit && !w_byte[PWR_RESUME] && force_resume;

  always_ff @(posedge aclk) begin
    if (!usb_rst_n) begin
      state       <= UFDC_ACTIVE; // see [RULE8]
      resume_seen <= 1'b0;
    end else begin
      case (state)
        UFDC_ACTIVE: begin
          if (suspend_event) begin
            state <= UFDC_SUSPEND; // see [RULE7]
          end
        end
        UFDC_SUSPEND: begin
          if (traffic_on && bus_reset_seen) begin
            state <= UFDC_ACTIVE; // see [RULE8]
          end else if (resume_event) begin
            state       <= UFDC_WAKE; // see [RULE9]
            resume_seen <= 1'b1;
          end else if (wr_power_hit && w_byte[PWR_RESUME]) begin
            state <= UFDC_WAKE;
          end
        end
        UFDC_WAKE: begin
          if ((traffic_on && bus_reset_seen) || wake_end ||
              (resume_seen && rd_cm_hit)) begin
            state       <= UFDC_ACTIVE; // see [RULE10] see [RULE12]
            resume_seen <= 1'b0;
          end
        end
        default: state <= UFDC_ACTIVE;
      endcase
    end
  end

  // flags: set wins over read clear; set only when enabled, except the reset flag on bus reset
  always_ff @(posedge aclk) begin
    if (!usb_rst_n) begin
      in_endpoint_irq_flags   <= 4'h0;
      common_irq_flags        <= 4'h0;
      in_endpoint_irq_enables <= RST_IN_EP_ENABLES; // see [RULE22]
      common_irq_enables      <= RST_COMMON_ENABLES;
    end else if (traffic_on && bus_reset_seen) begin
      in_endpoint_irq_enables <= RST_IN_EP_ENABLES; // see [RULE4]
      common_irq_enables      <= BUS_RESET_COMMON_EN | (common_irq_enables & 4'h1);
      in_endpoint_irq_flags   <= 4'h0;
      common_irq_flags        <= {1'b0, BUS_RESET_COMMON_EN[CM_RESET], 2'b00}; // see [RULE21]
    end else begin
      if (wr_fire && w_lane0 && aw_index == IDX_IN_EP_ENABLES) begin
        in_endpoint_irq_enables <= w_byte[3:0];
      end
      if (wr_fire && w_lane0 && aw_index == IDX_COMMON_ENABLES) begin
        common_irq_enables <= w_byte[3:0];
      end
      in_endpoint_irq_flags <= (rd_in_hit ? 4'h0 : in_endpoint_irq_flags) // see [RULE19]
        | (traffic_on ? (in_endpoint_event & in_endpoint_irq_enables) : 4'h0); // see [RULE23]
      common_irq_flags <= (rd_cm_hit ? 4'h0 : common_irq_flags)
        | ({(traffic_on && bus_sof), 1'b0, (resume_event || wake_end), suspend_event}
           & common_irq_enables); // see [RULE21] see [RULE9] see [RULE10]
    end
  end

  // outputs from flip-flops
  always_ff @(posedge aclk) begin
    if (!usb_rst_n) begin
      usb_irq         <= 1'b0;
      drive_resume    <= 1'b0;
      endpoint_flush  <= 1'b0;
      in_packet_armed <= 4'hF;
    end else begin
      usb_irq         <= (in_endpoint_irq_flags != 4'h0) || (common_irq_flags != 4'h0); // see [RULE18]
      drive_resume    <= force_resume && (state == UFDC_WAKE); // see [RULE10]
      endpoint_flush  <= traffic_on && bus_reset_seen; // see [RULE3]
      in_packet_armed <= armed_raw & {4{traffic_on}};
    end
  end

  ufdc_iso_gate u_iso_gate (
    .aclk        (aclk),
    .aresetn     (usb_rst_n),
    .gate_on     (iso_sof_gating),
    .bus_sof     (bus_sof),
    .ready_set   (in_packet_ready_set),
    .ready_clear (in_packet_sent),
    .ready_armed (armed_raw)
  );

  a_irq_follows_flags: assert property (@(posedge aclk) disable iff (!usb_rst_n)
    ((in_endpoint_irq_flags != 4'h0) || (common_irq_flags != 4'h0)) |=> usb_irq)
    else $error("irq not raised after flag"); // see [RULE18]
  a_in_read_clears: assert property (@(posedge aclk) disable iff (!usb_rst_n)
    (rd_in_hit && !(traffic_on && bus_reset_seen) && in_endpoint_event == 4'h0)
    |=> in_endpoint_irq_flags == 4'h0)
    else $error("in flags not cleared by read"); // see [RULE19]
  a_addr_pending_set: assert property (@(posedge aclk) disable iff (!usb_rst_n)
    (wr_addr_hit && !(traffic_on && bus_reset_seen)) |=> address_pending)
    else $error("pending not set by address write"); // see [RULE1]
  a_addr_applied: assert property (@(posedge aclk) disable iff (!usb_rst_n)
    (address_pending && request_done && !wr_addr_hit && !bus_reset_seen)
    |=> (!address_pending && active_address == $past(new_address)))
    else $error("address not applied"); // see [RULE2]
  a_bus_reset_zero: assert property (@(posedge aclk) disable iff (!usb_rst_n)
    (traffic_on && bus_reset_seen) |=> (active_address == 7'h00 &&
    in_endpoint_irq_enables == 4'hF))
    else $error("bus reset did not clear state"); // see [RULE3]
  a_inhibit_sticky: assert property (@(posedge aclk) disable iff (!usb_rst_n)
    !function_inhibit |=> !function_inhibit)
    else $error("inhibit set by software"); // see [RULE15]
  a_inhibit_quiet: assert property (@(posedge aclk) disable iff (!usb_rst_n)
    (function_inhibit && state == UFDC_ACTIVE) |=> state == UFDC_ACTIVE)
    else $error("suspend entered while inhibited"); // see [RULE16]
  a_suspend_enter: assert property (@(posedge aclk) disable iff (!usb_rst_n)
    suspend_event |=> state == UFDC_SUSPEND ##1 (usb_irq || !common_irq_enables[CM_SUSPEND]))
    else $error("suspend not entered"); // see [RULE7]
  a_wake_ends: assert property (@(posedge aclk) disable iff (!usb_rst_n)
    wake_end |=> state == UFDC_ACTIVE)
    else $error("suspend mode not cleared"); // see [RULE10]
endmodule : ufdc_device_control

// ---- ufdc_host_model.sv ----
// host side model: drives bus reset, suspend, resume and frame start signalling
`timescale 1ns/1ps
module ufdc_host_model
  import ufdc_pkg::*;
(
  input  wire logic aclk,
  output logic      bus_reset_seen,
  output logic      bus_suspend_seen,
  output logic      bus_resume_seen,
  output logic      bus_sof
);
  initial begin
    bus_reset_seen   = 1'b0;
    bus_suspend_seen = 1'b0;
    bus_resume_seen  = 1'b0;
    bus_sof          = 1'b0;
  end
  // one cycle bus event: 0 suspend, 1 resume, 2 frame start
  task automatic bus_event(input int k);
    @(posedge aclk);
    bus_suspend_seen <= (k == 0);
    bus_resume_seen  <= (k == 1);
    bus_sof          <= (k == 2);
    @(posedge aclk);
    bus_suspend_seen <= 1'b0;
    bus_resume_seen  <= 1'b0;
    bus_sof          <= 1'b0;
  endtask : bus_event
  // reset signalling is a level held as long as the host keeps it
  task automatic bus_reset(input logic on);
    @(posedge aclk);
    bus_reset_seen <= on;
  endtask : bus_reset
endmodule : ufdc_host_model

// ---- ufdc_iso_gate.sv ----
// iso in gating: holds a ready packet until sof when gating is on
`timescale 1ns/1ps
module ufdc_iso_gate
  import ufdc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       gate_on,
  input  wire logic       bus_sof,
  input  wire logic [3:0] ready_set,
  input  wire logic [3:0] ready_clear,
  output logic      [3:0] ready_armed
);
  logic [3:0] waiting;
  // waiting marks a packet readied since the last sof and not yet sent
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waiting <= 4'h0;
    end else begin
      waiting <= (bus_sof ? 4'h0 : (waiting & ~ready_clear)) | ready_set;
    end
  end
  // armed when gating is off, or sof has passed since readiness
  assign ready_armed = gate_on ? ~waiting : 4'hF; // see [RULE13] see [RULE14]
endmodule : ufdc_iso_gate

// ---- ufdc_pkg.sv ----
// package for usb function device control: offsets, fields, resets, states
package ufdc_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_FUNCTION_ADDRESS = 8'h00;
  localparam logic [7:0] IDX_POWER_CONTROL    = 8'h01;
  localparam logic [7:0] IDX_IN_EP_FLAGS      = 8'h02;
  localparam logic [7:0] IDX_COMMON_FLAGS     = 8'h06;
  localparam logic [7:0] IDX_IN_EP_ENABLES    = 8'h07;
  localparam logic [7:0] IDX_COMMON_ENABLES   = 8'h0B;
  localparam logic [7:0] IDX_EVENT_STATUS     = 8'h10;
  // power_control fields, then the function address pending bit
  localparam int PWR_SUSPEND_EN  = 0;
  localparam int PWR_SUSPEND_MD  = 1;
  localparam int PWR_RESUME      = 2;
  localparam int PWR_RESET       = 3;
  localparam int PWR_INHIBIT     = 4;
  localparam int PWR_ISO_GATE    = 7;
  localparam int FUNCTION_ADDRESS_PENDING   = 7;
  // common flag fields
  localparam int CM_SUSPEND = 0;
  localparam int CM_RESUME  = 1;
  localparam int CM_RESET   = 2;
  localparam int CM_SOF     = 3;
  // reset values
  localparam logic [7:0] RST_POWER_CONTROL  = 8'h10;
  localparam logic [7:0] RST_FUNC_ADDRESS   = 8'h00;
  localparam logic [3:0] RST_IN_EP_ENABLES  = 4'hF;
  localparam logic [3:0] RST_COMMON_ENABLES = 4'h6;
  localparam logic [3:0] BUS_RESET_COMMON_EN = 4'hE;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // software reset pulse length
  localparam int         SOFT_RESET_NS     = 8;
  localparam int         CLOCK_PERIOD_NS   = 4;
  localparam logic [1:0] SOFT_RESET_CYCLES =
    2'((SOFT_RESET_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  typedef enum logic [1:0] {
    UFDC_ACTIVE  = 2'b00,
    UFDC_SUSPEND = 2'b01,
    UFDC_WAKE    = 2'b10
  } ufdc_state_type;
endpackage : ufdc_pkg
